// File: pmc_pd_model.sv
// Purpose: Behavioural port front end that reports one port per cycle.
// Assumes: Bench sets each port's state through set_pd.
// Notes: Reports repeat round robin, as a real metering scan would.
`timescale 1ns/1ps
`default_nettype none

module pmc_pd_model
	import pmc_pkg::*;
#(
	parameter int NPORT = 4
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// Report to the policy engine
	output var pmc_sample_s sample_o
);
	logic pres [NPORT];
	logic [31:0] req [NPORT];
	logic [31:0] cons [NPORT];
	logic [7:0] idx_q;

	// Open circuit reported as present low
	// Changes land just after a rising edge so the engine never races them
	task set_pd(input int p, input logic pr, input logic [31:0] r, input logic [31:0] c);
		@(posedge sys_clk_i);
		pres[p] <= pr;
		req[p] <= r;
		cons[p] <= c;
	endtask : set_pd

	initial begin
		for (int i = 0; i < NPORT; i++) begin
			pres[i] <= 1'b0;
			req[i] <= 32'h0;
			cons[i] <= 32'h0;
		end
	end

	// Scan index walks the ports
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			idx_q <= 8'h00;
		end else begin
			idx_q <= (idx_q == 8'(NPORT - 1)) ? 8'h00 : idx_q + 8'h01;
		end
	end

	// Connect and disconnect are seen within one scan
	always_comb begin
		sample_o = {!rst_i, idx_q, pres[idx_q], req[idx_q], cons[idx_q]};
	end
endmodule : pmc_pd_model

`default_nettype wire

// File: pmc_pkg.sv
// Purpose: Shared constants and carriers for the port power policy engine.
// Assumes: Byte addressed Avalon-MM register window, 32-bit data.
// Notes: Routine codes and register offsets are local to this engine.
package pmc_pkg;

	// Register byte offsets
	localparam logic [7:0] REG_ROUTINE = 8'h00;
	localparam logic [7:0] REG_BYTE_ARG = 8'h04;
	localparam logic [7:0] REG_WORD_ARG = 8'h08;
	localparam logic [7:0] REG_REPLY_BYTE = 8'h0C;
	localparam logic [7:0] REG_REPLY_WORD = 8'h10;
	localparam logic [7:0] REG_PROVIDED = 8'h14;
	localparam logic [7:0] REG_REMAINING = 8'h18;

	// Routine codes written to REG_ROUTINE
	localparam logic [7:0] set_port_drive_mode_routine = 8'h01;
	localparam logic [7:0] regrant_port_power_routine = 8'h02;
	localparam logic [7:0] set_supply_capacity_routine = 8'h03;
	localparam logic [7:0] get_supply_capacity_routine = 8'h04;
	localparam logic [7:0] set_reserve_percent_routine = 8'h05;
	localparam logic [7:0] get_reserve_percent_routine = 8'h06;
	localparam logic [7:0] set_overload_threshold_routine = 8'h07;
	localparam logic [7:0] get_overload_threshold_routine = 8'h08;
	localparam logic [7:0] set_grant_method_routine = 8'h09;
	localparam logic [7:0] get_grant_method_routine = 8'h0A;
	localparam logic [7:0] set_recovery_method_routine = 8'h0B;
	localparam logic [7:0] get_recovery_method_routine = 8'h0C;
	localparam logic [7:0] set_headroom_percent_routine = 8'h0D;
	localparam logic [7:0] get_headroom_percent_routine = 8'h0E;
	localparam logic [7:0] set_zero_power_boot_routine = 8'h0F;
	localparam logic [7:0] get_zero_power_boot_routine = 8'h10;
	localparam logic [7:0] enable_port_routine = 8'h11;

	// Reply codes in the byte reply
	localparam logic [7:0] ERR_NONE = 8'h00;
	localparam logic [7:0] ERR_ROUTINE = 8'h01;
	localparam logic [7:0] ERR_RANGE = 8'h02;
	localparam logic [7:0] ERR_NOT_ON = 8'h03;
	localparam logic [7:0] ERR_NO_POWER = 8'h04;

	// Drive modes
	localparam logic [1:0] CTRL_AUTO = 2'h0;
	localparam logic [1:0] CTRL_FORCE_ON = 2'h1;
	localparam logic [1:0] CTRL_FORCE_OFF = 2'h2;

	// Active priority levels
	localparam logic [1:0] PRIO_LOW = 2'h0;
	localparam logic [1:0] PRIO_HIGH = 2'h1;
	localparam logic [1:0] PRIO_FORCED = 2'h2;
	localparam logic [1:0] PRIO_CRIT = 2'h3;

	// Grant methods and recovery methods
	localparam logic GRANT_BY_GRANTS = 1'h0;
	localparam logic GRANT_BY_USAGE = 1'h1;
	localparam logic [1:0] RECOVER_IMMEDIATE = 2'h0;
	localparam logic [1:0] RECOVER_ON_RECONNECT = 2'h1;
	localparam logic [1:0] RECOVER_ON_USER_ENABLE = 2'h2;

	// Limits of settings
	localparam logic [7:0] PCT_FULL = 8'h64;
	localparam logic [7:0] HEADROOM_MAX = 8'h19;
	localparam logic [7:0] SUPPLY_FIRST = 8'h01;
	localparam logic [7:0] SUPPLY_LAST = 8'h03;
	localparam int SUPPLIES = 3;

	// Avalon request from the master
	typedef struct packed {
		logic read;
		logic write;
		logic [7:0] address;
		logic [31:0] writedata;
	} pmc_avm_req_s;

	// One port report from the detection and metering front end
	typedef struct packed {
		logic valid;
		logic [7:0] port;
		logic present;
		logic [31:0] req_mw;
		logic [31:0] cons_mw;
	} pmc_sample_s;

endpackage : pmc_pkg

// File: pmc_port_policy.sv
// Purpose: Routine interpreter and power policy engine for a bank of PSE ports.
// Assumes: Arguments are written before the routine code; one port scanned per cycle.
// Notes: Sums of supplies and grants are 32-bit and must not exceed 4.29 MW.
//
// Contract
// (RULE1) Drive mode routine: port, code 0/1/2
// (RULE2) Automatic ports follow PD connect and disconnect
// (RULE3) Force-on raises active priority to forced
// (RULE4) Never shed critical port for forced port
// (RULE5) Granted forced port powers without a PD
// (RULE6) Force-off turns port off and holds
// (RULE7) Force-off is temporary, disable is permanent
// (RULE8) Regrant changes grant of a live port
// (RULE9) Regrant refused when port is off
// (RULE10) Supply capacity routines address supplies 1-3
// (RULE11) Usage mode keeps reserve percent ungranted
// (RULE12) Mild overload sheds ports one by one
// (RULE13) Severe overload drops all low ports
// (RULE14) Grant method 0 grants, 1 usage
// (RULE15) Grants mode: provided minus granted
// (RULE16) Usage mode: provided minus used minus reserve
// (RULE17) Grant when remaining at least request
// (RULE18) Over-grant draw flags overload, port off
// (RULE19) Immediate recovery retries at once
// (RULE20) Reconnect recovery waits for open then PD
// (RULE21) User-enable recovery disables port until enabled
// (RULE22) Global headroom 0 to 25 percent
// (RULE23) Zero-power boot starts with no supply
// (RULE24) Host then sets real supply capacity
// (RULE25) Set replies zero or error, keep value
//
// The Avalon-MM interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module pmc_port_policy
	import pmc_pkg::*;
#(
	parameter int NPORT = 64,
	parameter logic ZERO_BOOT_DEF = 1'b1,
	parameter logic [31:0] SUPPLY_DEF_MW = 32'h0001_D4C0
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// Register bus
	input wire pmc_avm_req_s avm_req_i,
	output logic [31:0] avm_readdata_o,
	output logic avm_waitrequest_o,
	// Port front end
	input wire pmc_sample_s sample_i,
	input wire logic [2*NPORT-1:0] port_prio_i,
	// Port drive and status
	output logic [NPORT-1:0] port_on_o,
	output logic [NPORT-1:0] port_ovl_o,
	output logic [NPORT-1:0] port_disabled_o
);

	localparam int PW = (NPORT > 1) ? $clog2(NPORT) : 1;

	// Percentage of a value, truncated
	function automatic logic [31:0] pct_of(input logic [31:0] v, input logic [7:0] p);
		logic [39:0] t;
		t = 40'(v) * 40'(p);
		return 32'(t / 40'(PCT_FULL));
	endfunction : pct_of

	// Active priority: forced modes lift low and high to forced
	function automatic logic [1:0] act_prio(input logic [1:0] cfg, input logic [1:0] ctrl);
		if (ctrl != CTRL_AUTO && cfg < PRIO_FORCED) begin
			return PRIO_FORCED;
		end
		return cfg;
	endfunction : act_prio

	// Configuration state
	logic [31:0] supply_q [SUPPLIES];
	logic [7:0] reserve_q;
	logic [7:0] ovl_limit_q;
	logic grant_mode_q;
	logic [1:0] recover_q;
	logic [7:0] headroom_q;
	logic zero_boot_q;
	logic [7:0] byte_arg_q;
	logic [31:0] word_arg_q;
	logic [7:0] reply_byte_q;
	logic [31:0] reply_word_q;

	// Bus handshake state
	logic wait_q;
	logic [31:0] rdata_q;

	// Per-port state
	logic [1:0] ctrl_q [NPORT];
	logic [31:0] req_q [NPORT];
	logic [31:0] cons_q [NPORT];
	logic [31:0] grant_q [NPORT];
	logic [NPORT-1:0] on_q;
	logic [NPORT-1:0] dis_q;
	logic [NPORT-1:0] blk_q;
	logic [NPORT-1:0] ovl_q;
	logic [NPORT-1:0] pres_q;
	logic [PW-1:0] scan_q;
	logic shed_done_q;
	logic preempt_q;

	// Bus decode
	logic bus_req;
	logic wr_go;
	logic cmd_go;
	logic [7:0] cmd_code;
	logic port_ok;
	logic [PW-1:0] bp;
	assign bus_req = avm_req_i.read | avm_req_i.write;
	assign wr_go = avm_req_i.write & ~wait_q;
	assign cmd_go = wr_go && avm_req_i.address == REG_ROUTINE;
	assign cmd_code = avm_req_i.writedata[7:0];
	assign port_ok = int'(byte_arg_q) < NPORT;
	assign bp = byte_arg_q[PW-1:0];

	// Power totals: grants and lowest priority over live ports, draw over all ports
	logic [31:0] prov_mw;
	logic [31:0] tot_grant;
	logic [31:0] tot_cons;
	logic [1:0] min_prio;
	always_comb begin
		prov_mw = '0;
		for (int s = 0; s < SUPPLIES; s++) begin
			prov_mw = 32'(prov_mw + supply_q[s]);
		end
		tot_grant = '0;
		tot_cons = '0;
		min_prio = PRIO_CRIT;
		for (int i = 0; i < NPORT; i++) begin
			if (on_q[i]) begin
				tot_grant = 32'(tot_grant + grant_q[i]);
				if (act_prio(port_prio_i[2*i +: 2], ctrl_q[i]) < min_prio) begin
					min_prio = act_prio(port_prio_i[2*i +: 2], ctrl_q[i]);
				end
			end
			tot_cons = 32'(tot_cons + cons_q[i]);
		end
	end

	// Remaining power per grant method, signed so a deficit stays visible
	logic [31:0] reserve_mw;
	logic signed [33:0] remain_s;
	assign reserve_mw = pct_of(prov_mw, reserve_q); // RULE11
	always_comb begin
		if (grant_mode_q == GRANT_BY_USAGE) begin // RULE14
			remain_s = $signed({2'b00, prov_mw}) - $signed({2'b00, tot_cons})
				- $signed({2'b00, reserve_mw}); // RULE16
		end else begin
			remain_s = $signed({2'b00, prov_mw}) - $signed({2'b00, tot_grant}); // RULE15
		end
	end

	// Overload grading: severe when excess beyond the limit percentage
	logic sys_ovl;
	logic [31:0] over_mw;
	logic severe;
	assign sys_ovl = tot_cons > prov_mw;
	assign over_mw = sys_ovl ? 32'(tot_cons - prov_mw) : '0;
	assign severe = sys_ovl && (40'(over_mw) * 40'(PCT_FULL) > 40'(prov_mw) * 40'(ovl_limit_q));

	// Routine decode: error code and reply word
	logic [7:0] cmd_err;
	logic [7:0] cmd_rbyte;
	logic [31:0] cmd_rword;
	logic [31:0] regrant_delta;
	always_comb begin
		cmd_err = ERR_NONE;
		cmd_rbyte = ERR_NONE;
		cmd_rword = '0;
		regrant_delta = '0;
		unique case (cmd_code)
			set_port_drive_mode_routine: begin
				if (!port_ok || word_arg_q > 32'(CTRL_FORCE_OFF)) begin
					cmd_err = ERR_RANGE; // RULE1
				end
			end
			regrant_port_power_routine: begin
				if (!port_ok) begin
					cmd_err = ERR_RANGE;
				end else if (!on_q[bp]) begin
					cmd_err = ERR_NOT_ON; // RULE9
				end else if (word_arg_q > grant_q[bp]) begin
					regrant_delta = 32'(word_arg_q - grant_q[bp]);
					if (remain_s < $signed({2'b00, regrant_delta})) begin
						cmd_err = ERR_NO_POWER; // RULE17
					end
				end
			end
			set_supply_capacity_routine, get_supply_capacity_routine: begin
				if (byte_arg_q < SUPPLY_FIRST || byte_arg_q > SUPPLY_LAST) begin
					cmd_err = ERR_RANGE; // RULE10
				end else if (cmd_code == get_supply_capacity_routine) begin
					cmd_rword = supply_q[2'(byte_arg_q - SUPPLY_FIRST)];
				end
			end
			set_reserve_percent_routine, set_overload_threshold_routine: begin
				if (byte_arg_q > PCT_FULL) begin
					cmd_err = ERR_RANGE;
				end
			end
			set_grant_method_routine, set_zero_power_boot_routine: begin
				if (byte_arg_q > 8'h01) begin
					cmd_err = ERR_RANGE;
				end
			end
			set_recovery_method_routine: begin
				if (byte_arg_q > 8'(RECOVER_ON_USER_ENABLE)) begin
					cmd_err = ERR_RANGE;
				end
			end
			set_headroom_percent_routine: begin
				if (byte_arg_q > HEADROOM_MAX) begin
					cmd_err = ERR_RANGE; // RULE22
				end
			end
			enable_port_routine: begin
				if (!port_ok) begin
					cmd_err = ERR_RANGE;
				end
			end
			get_reserve_percent_routine: cmd_rbyte = reserve_q;
			get_overload_threshold_routine: cmd_rbyte = ovl_limit_q;
			get_grant_method_routine: cmd_rbyte = 8'(grant_mode_q);
			get_recovery_method_routine: cmd_rbyte = 8'(recover_q);
			get_headroom_percent_routine: cmd_rbyte = headroom_q;
			get_zero_power_boot_routine: cmd_rbyte = 8'(zero_boot_q);
			default: cmd_err = ERR_ROUTINE;
		endcase
		if (cmd_err != ERR_NONE) begin
			cmd_rbyte = cmd_err; // RULE25
			cmd_rword = '0;
		end
	end

	// Waitrequest: one wait cycle, then a one-cycle acknowledge
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wait_q <= 1'b1;
		end else begin
			wait_q <= ~(bus_req & wait_q);
		end
	end

	// Read data captured in the wait cycle, unmapped reads give zero
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_q <= '0;
		end else if (avm_req_i.read && wait_q) begin
			unique case (avm_req_i.address)
				REG_BYTE_ARG: rdata_q <= 32'(byte_arg_q);
				REG_WORD_ARG: rdata_q <= word_arg_q;
				REG_REPLY_BYTE: rdata_q <= 32'(reply_byte_q);
				REG_REPLY_WORD: rdata_q <= reply_word_q;
				REG_PROVIDED: rdata_q <= prov_mw;
				REG_REMAINING: rdata_q <= remain_s[33] ? '0 : remain_s[31:0];
				default: rdata_q <= '0;
			endcase
		end
	end
	assign avm_readdata_o = rdata_q;
	assign avm_waitrequest_o = wait_q;

	// Argument registers
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			byte_arg_q <= '0;
			word_arg_q <= '0;
		end else if (wr_go && avm_req_i.address == REG_BYTE_ARG) begin
			byte_arg_q <= avm_req_i.writedata[7:0];
		end else if (wr_go && avm_req_i.address == REG_WORD_ARG) begin
			word_arg_q <= avm_req_i.writedata;
		end
	end

	// System settings; a refused set leaves the value alone
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int s = 0; s < SUPPLIES; s++) begin
				supply_q[s] <= ZERO_BOOT_DEF ? '0 : SUPPLY_DEF_MW; // RULE23
			end
			reserve_q <= '0;
			ovl_limit_q <= '0;
			grant_mode_q <= GRANT_BY_GRANTS;
			recover_q <= RECOVER_IMMEDIATE;
			headroom_q <= '0;
			zero_boot_q <= ZERO_BOOT_DEF;
			reply_byte_q <= ERR_NONE;
			reply_word_q <= '0;
		end else if (cmd_go) begin
			reply_byte_q <= cmd_rbyte; // RULE25
			reply_word_q <= cmd_rword;
			if (cmd_err == ERR_NONE) begin
				unique case (cmd_code)
					set_supply_capacity_routine: begin
						supply_q[2'(byte_arg_q - SUPPLY_FIRST)] <= word_arg_q; // RULE10 RULE24
					end
					set_reserve_percent_routine: reserve_q <= byte_arg_q;
					set_overload_threshold_routine: ovl_limit_q <= byte_arg_q;
					set_grant_method_routine: grant_mode_q <= byte_arg_q[0]; // RULE14
					set_recovery_method_routine: recover_q <= byte_arg_q[1:0];
					set_headroom_percent_routine: headroom_q <= byte_arg_q; // RULE22
					set_zero_power_boot_routine: zero_boot_q <= byte_arg_q[0];
					default: ;
				endcase
			end
		end
	end

	// Scanned port view
	logic [1:0] s_prio;
	logic s_wants;
	logic s_over;
	logic s_shed;
	logic s_fits;
	assign s_prio = act_prio(port_prio_i[2*scan_q +: 2], ctrl_q[scan_q]); // RULE3
	assign s_wants = !dis_q[scan_q] && !blk_q[scan_q] && (ctrl_q[scan_q] == CTRL_FORCE_ON
		|| (ctrl_q[scan_q] == CTRL_AUTO && pres_q[scan_q]));
	assign s_over = cons_q[scan_q] > pct_of(grant_q[scan_q], 8'(PCT_FULL + headroom_q)); // RULE22
	assign s_fits = remain_s >= $signed({2'b00, req_q[scan_q]}); // RULE17
	// Lowest live priority goes first; critical ports are never picked
	assign s_shed = on_q[scan_q] && s_prio == min_prio && min_prio != PRIO_CRIT
		&& !shed_done_q && ((sys_ovl && !severe) || (preempt_q && min_prio < PRIO_FORCED));

	// Port engine: reports, routines, severe shedding and the scan
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < NPORT; i++) begin
				ctrl_q[i] <= CTRL_AUTO;
				req_q[i] <= '0;
				cons_q[i] <= '0;
				grant_q[i] <= '0;
			end
			on_q <= '0;
			dis_q <= '0;
			blk_q <= '0;
			ovl_q <= '0;
			pres_q <= '0;
			scan_q <= '0;
			shed_done_q <= 1'b0;
			preempt_q <= 1'b0;
		end else begin
			// Front-end report; an open port lifts a reconnect block
			if (sample_i.valid && int'(sample_i.port) < NPORT) begin
				pres_q[sample_i.port[PW-1:0]] <= sample_i.present;
				req_q[sample_i.port[PW-1:0]] <= sample_i.req_mw;
				cons_q[sample_i.port[PW-1:0]] <= sample_i.cons_mw;
				if (!sample_i.present) begin
					blk_q[sample_i.port[PW-1:0]] <= 1'b0; // RULE20
				end
			end
			// Routine effects on ports
			if (cmd_go && cmd_err == ERR_NONE) begin
				if (cmd_code == set_port_drive_mode_routine) begin
					ctrl_q[bp] <= word_arg_q[1:0]; // RULE1
				end
				if (cmd_code == regrant_port_power_routine) begin
					grant_q[bp] <= word_arg_q; // RULE8
				end
				if (cmd_code == enable_port_routine) begin
					dis_q[bp] <= 1'b0; // RULE21
				end
			end
			// Severe overload: every live low port drops together
			if (severe) begin
				for (int i = 0; i < NPORT; i++) begin
					if (on_q[i] && act_prio(port_prio_i[2*i +: 2], ctrl_q[i]) == PRIO_LOW) begin
						on_q[i] <= 1'b0; // RULE13
					end
				end
			end
			// One port per cycle
			if (ctrl_q[scan_q] == CTRL_FORCE_OFF || dis_q[scan_q]) begin
				on_q[scan_q] <= 1'b0; // RULE6 RULE7
			end else if (on_q[scan_q] && s_over) begin
				on_q[scan_q] <= 1'b0; // RULE18
				ovl_q[scan_q] <= 1'b1;
				if (recover_q == RECOVER_ON_RECONNECT) begin
					blk_q[scan_q] <= 1'b1; // RULE20
				end else if (recover_q == RECOVER_ON_USER_ENABLE) begin
					dis_q[scan_q] <= 1'b1; // RULE21
				end
			end else if (on_q[scan_q] && ctrl_q[scan_q] == CTRL_AUTO && !pres_q[scan_q]) begin
				on_q[scan_q] <= 1'b0; // RULE2
			end else if (s_shed) begin
				on_q[scan_q] <= 1'b0; // RULE12 RULE4
				shed_done_q <= 1'b1;
				preempt_q <= 1'b0;
			end else if (!on_q[scan_q] && s_wants && !severe) begin
				// Immediate recovery needs no extra state: next pass retries
				if (s_fits) begin
					on_q[scan_q] <= 1'b1; // RULE2 RULE5 RULE19
					grant_q[scan_q] <= req_q[scan_q];
					ovl_q[scan_q] <= 1'b0;
				end else if (ctrl_q[scan_q] == CTRL_FORCE_ON) begin
					preempt_q <= 1'b1; // RULE3
				end
			end
			if (int'(scan_q) == NPORT - 1) begin
				scan_q <= '0;
				shed_done_q <= 1'b0;
			end else begin
				scan_q <= PW'(scan_q + 1'b1);
			end
		end
	end
	assign port_on_o = on_q;
	assign port_ovl_o = ovl_q;
	assign port_disabled_o = dis_q;

	// Checks
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	a_force_off_held: assert property ((ctrl_q[0] == CTRL_FORCE_OFF && scan_q == '0) |=> !on_q[0]) // RULE6
		else $error("forced-off port 0 still on");
	a_drive_code_store: assert property ((cmd_go && cmd_code == set_port_drive_mode_routine // RULE1
		&& byte_arg_q == 8'h00 && cmd_err == ERR_NONE) |=> ctrl_q[0] == $past(word_arg_q[1:0]))
		else $error("drive mode not stored");
	a_regrant_off_refused: assert property ((cmd_go && cmd_code == regrant_port_power_routine // RULE9
		&& port_ok && !on_q[bp]) |=> reply_byte_q == ERR_NOT_ON)
		else $error("regrant of off port not refused");
	a_grant_fits: assert property ($rose(on_q[0]) |-> $past(remain_s) >= $signed({2'b00, $past(req_q[0])})) // RULE17
		else $error("port granted without remaining power");
	a_severe_low_shed: assert property ((severe && on_q[0] // RULE13
		&& act_prio(port_prio_i[1:0], ctrl_q[0]) == PRIO_LOW) |=> !on_q[0])
		else $error("low port survived severe overload");
	a_headroom_bound: assert property (headroom_q <= HEADROOM_MAX) // RULE22
		else $error("headroom above limit");
	a_reserve_refused: assert property ((cmd_go && cmd_code == set_reserve_percent_routine // RULE25
		&& byte_arg_q > PCT_FULL) |=> reserve_q == $past(reserve_q) && reply_byte_q == ERR_RANGE)
		else $error("bad reserve not refused");
	// A healthy live critical port must survive its scan slot whatever shedding wants
	a_crit_never_shed: assert property ((on_q[0] && scan_q == '0 && ctrl_q[0] == CTRL_AUTO // RULE4
		&& port_prio_i[1:0] == PRIO_CRIT && pres_q[0] && !dis_q[0] && !s_over) |=> on_q[0])
		else $error("critical port picked for shedding");
	a_bus_one_wait: assert property ((bus_req && wait_q) |=> !avm_waitrequest_o ##1 avm_waitrequest_o)
		else $error("waitrequest not one cycle");

	c_forced_power: cover property (ctrl_q[0] == CTRL_FORCE_ON && !pres_q[0] && $rose(on_q[0]));
	c_severe_event: cover property ($rose(severe));
	c_regrant_ok: cover property (cmd_go && cmd_code == regrant_port_power_routine && cmd_err == ERR_NONE);
	c_overload_trip: cover property ($rose(ovl_q[0]));

endmodule : pmc_port_policy

`default_nettype wire

// File: poe_port_ctrl_sys_config_tb.sv
// Purpose: Self-checking bench for the port policy engine.
// Assumes: Four ports; front end given by the partner model.
// Notes: Bus driven and sampled on the rising edge; port outputs read at the falling one.
`timescale 1ns/1ps
`default_nettype none

module poe_port_ctrl_sys_config_tb;
	import pmc_pkg::*;
	typedef struct {logic [7:0] c; logic [7:0] b; logic [31:0] w; logic [7:0] r;} pmc_row_s;
	logic sys_clk_i = 1'b0;
	logic rst_i = 1'b1;
	pmc_avm_req_s req = '0;
	pmc_sample_s smp;
	logic [7:0] prio = 8'hC4;
	logic [31:0] rdata;
	logic wrq;
	logic [3:0] on, ovl, dis;
	logic [31:0] v;
	int n_mismatch = 0;
	int comparisons = 0;
	int cyc = 0;
	pmc_row_s rows [$] = '{
		'{8'h05, 8'h32, 0, 8'h00}, '{8'h06, 0, 0, 8'h32}, '{8'h05, 8'h65, 0, 8'h02},
		'{8'h06, 0, 0, 8'h32}, '{8'h05, 8'h0A, 0, 8'h00}, '{8'h07, 8'h64, 0, 8'h00},
		'{8'h07, 8'h65, 0, 8'h02}, '{8'h08, 0, 0, 8'h64}, '{8'h09, 8'h02, 0, 8'h02},
		'{8'h0A, 0, 0, 8'h00}, '{8'h0B, 8'h03, 0, 8'h02}, '{8'h0B, 8'h01, 0, 8'h00},
		'{8'h0C, 0, 0, 8'h01}, '{8'h0B, 8'h02, 0, 8'h00}, '{8'h0C, 0, 0, 8'h02},
		'{8'h0D, 8'h1A, 0, 8'h02}, '{8'h0D, 8'h19, 0, 8'h00}, '{8'h0E, 0, 0, 8'h19},
		'{8'h0F, 8'h02, 0, 8'h02}, '{8'h0F, 8'h00, 0, 8'h00}, '{8'h10, 0, 0, 8'h00},
		'{8'h03, 8'h00, 1, 8'h02}, '{8'h03, 8'h04, 1, 8'h02}, '{8'h01, 8'h00, 3, 8'h02},
		'{8'h20, 0, 0, 8'h01}};

	pmc_port_policy #(.NPORT(4)) pmc_port_policy_i (
		.sys_clk_i(sys_clk_i), .rst_i(rst_i), .avm_req_i(req), .avm_readdata_o(rdata),
		.avm_waitrequest_o(wrq), .sample_i(smp), .port_prio_i(prio), .port_on_o(on),
		.port_ovl_o(ovl), .port_disabled_o(dis));
	pmc_pd_model #(.NPORT(4)) pmc_pd_model_i (
		.sys_clk_i(sys_clk_i), .rst_i(rst_i), .sample_o(smp));

	initial begin
		forever #5 sys_clk_i = ~sys_clk_i;
	end

	// Hang guard, well above the planned run
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc > 20000) begin
			n_mismatch++;
			results();
		end
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t %s seen %h exp %h", $time, m, seen, exp);
		end
	endtask : chk

	// One Avalon transfer; request held until the edge that samples waitrequest low
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q);
		@(posedge sys_clk_i);
		req <= {!w, w, a, d};
		do @(posedge sys_clk_i); while (wrq !== 1'b0);
		q = rdata;
		req <= '0;
	endtask : bus

	// Arguments first, then the code, then the reply byte
	task automatic rt(input logic [7:0] c, input logic [7:0] b, input logic [31:0] w,
			output logic [31:0] q);
		bus(1'b1, REG_BYTE_ARG, {24'h0, b}, q);
		bus(1'b1, REG_WORD_ARG, w, q);
		bus(1'b1, REG_ROUTINE, {24'h0, c}, q);
		bus(1'b0, REG_REPLY_BYTE, 32'h0, q);
	endtask : rt

	task automatic rdx(input logic [7:0] a, input logic [31:0] e, input string m);
		bus(1'b0, a, 32'h0, v);
		chk(v, e, m);
	endtask : rdx

	// Bounded wait for a port output, then compare
	task automatic wt(input int p, input logic e, input int lim, input string m);
		int n;
		n = 0;
		while (on[p] !== e && n < lim) begin
			@(negedge sys_clk_i);
			n++;
		end
		chk({31'h0, on[p]}, {31'h0, e}, m);
	endtask : wt

	task results;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : results

	initial begin
		repeat (4) @(posedge sys_clk_i);
		chk({31'h0, wrq}, 32'h1, "wait in reset");
		chk({28'h0, on}, 32'h0, "ports in reset");
		rst_i <= 1'b0;
		@(posedge sys_clk_i);
		rdx(REG_PROVIDED, 32'h0, "zero boot");
		rdx(8'h40, 32'h0, "unmapped");
		$display("test reset done");
		foreach (rows[i]) begin
			rt(rows[i].c, rows[i].b, rows[i].w, v);
			chk(v, {24'h0, rows[i].r}, "table reply");
		end
		$display("test settings done");
		// Host loads real supply figures after a zero boot
		rt(set_supply_capacity_routine, 8'h01, 32'h2710, v);
		rt(set_supply_capacity_routine, 8'h02, 32'h1388, v);
		rdx(REG_PROVIDED, 32'h3A98, "provided");
		rt(get_supply_capacity_routine, 8'h01, 32'h0, v);
		rdx(REG_REPLY_WORD, 32'h2710, "get supply");
		pmc_pd_model_i.set_pd(0, 1'b1, 32'h1770, 32'h3E8);
		wt(0, 1'b1, 20, "auto on");
		rdx(REG_REMAINING, 32'h2328, "grant remaining");
		pmc_pd_model_i.set_pd(1, 1'b1, 32'h2329, 32'h3E8);
		repeat (20) @(negedge sys_clk_i);
		chk({31'h0, on[1]}, 32'h0, "denied one over");
		pmc_pd_model_i.set_pd(1, 1'b1, 32'h2328, 32'h3E8);
		wt(1, 1'b1, 20, "granted exact");
		rt(set_grant_method_routine, 8'h01, 32'h0, v);
		rdx(REG_REMAINING, 32'h2CEC, "usage remaining");
		rt(set_grant_method_routine, 8'h00, 32'h0, v);
		pmc_pd_model_i.set_pd(1, 1'b0, 32'h2328, 32'h0);
		wt(1, 1'b0, 20, "auto off");
		$display("test grant done");
		rt(set_port_drive_mode_routine, 8'h00, 32'h2, v);
		wt(0, 1'b0, 20, "forced off");
		repeat (20) @(negedge sys_clk_i);
		chk({31'h0, on[0]}, 32'h0, "held off");
		rt(set_port_drive_mode_routine, 8'h00, 32'h0, v);
		wt(0, 1'b1, 20, "back to auto");
		chk({31'h0, dis[0]}, 32'h0, "not disabled");
		pmc_pd_model_i.set_pd(2, 1'b0, 32'h7D0, 32'h0);
		rt(set_port_drive_mode_routine, 8'h02, 32'h1, v);
		wt(2, 1'b1, 20, "forced on no PD");
		rdx(REG_REMAINING, 32'h1B58, "forced grant");
		$display("test drive modes done");
		rt(regrant_port_power_routine, 8'h03, 32'h3E8, v);
		chk(v, {24'h0, ERR_NOT_ON}, "regrant off port");
		rt(regrant_port_power_routine, 8'h00, 32'hBB8, v);
		chk(v, 32'h0, "regrant live");
		rdx(REG_REMAINING, 32'h2710, "regrant remaining");
		$display("test regrant done");
		pmc_pd_model_i.set_pd(0, 1'b1, 32'h1770, 32'hE74);
		repeat (20) @(negedge sys_clk_i);
		chk({30'h0, ovl[0], on[0]}, 32'h1, "within headroom");
		pmc_pd_model_i.set_pd(0, 1'b1, 32'h1770, 32'hFA0);
		wt(0, 1'b0, 20, "overload off");
		chk({30'h0, ovl[0], dis[0]}, 32'h3, "flag and disable");
		pmc_pd_model_i.set_pd(0, 1'b1, 32'h1770, 32'h3E8);
		repeat (20) @(negedge sys_clk_i);
		chk({31'h0, on[0]}, 32'h0, "stays off");
		rt(enable_port_routine, 8'h00, 32'h0, v);
		wt(0, 1'b1, 20, "enabled again");
		chk({31'h0, dis[0]}, 32'h0, "disable cleared");
		$display("test overload done");
		// Excess of 2 W on 5 W is beyond a 10 percent limit: low ports drop at once
		rt(set_overload_threshold_routine, 8'h0A, 32'h0, v);
		pmc_pd_model_i.set_pd(0, 1'b1, 32'h1770, 32'h1B58);
		rt(set_supply_capacity_routine, 8'h01, 32'h1388, v);
		rt(set_supply_capacity_routine, 8'h02, 32'h0, v);
		wt(0, 1'b0, 20, "severe drop low");
		chk({31'h0, on[2]}, 32'h1, "forced port kept");
		$display("test severe done");
		// Mid-run reset brings back the zero-power boot state
		@(posedge sys_clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		chk({20'h0, on, ovl, dis}, 32'h0, "ports in second reset");
		rst_i <= 1'b0;
		@(posedge sys_clk_i);
		rdx(REG_PROVIDED, 32'h0, "zero boot again");
		rt(get_headroom_percent_routine, 8'h00, 32'h0, v);
		chk(v, 32'h0, "headroom default");
		$display("test second reset done");
		results();
	end
endmodule : poe_port_ctrl_sys_config_tb

`default_nettype wire
